// ### verilog/rtu_defs.vh
// constants for the return instruction unit
`ifndef RTU_DEFS_VH
`define RTU_DEFS_VH
// ====================================================================
// opcode encodings (14-bit program word)
`define RTU_OPW_RETINT      14'h0009
`define RTU_OPW_RETPLAIN    14'h0008
`define RTU_OPW_RETLIT_MASK 14'h3c00
`define RTU_OPW_RETLIT      14'h3400
// ====================================================================
// field positions and timing
`define RTU_GLOBAL_INT_EN_BIT 7
`define RTU_RET_CYCLES      4'h2
`define RTU_ACC_RST         8'h00
`define RTU_CTL_RST         8'h00
`define RTU_PC_RST          13'h0000
`endif

// ### verilog/rtu_op_decode.v
// opcode classifier for the return instructions
`timescale 1ns/1ps
`include "rtu_defs.vh"
module rtu_op_decode (
    input  wire [13:0] opcode_in,
    output wire        is_retint_out,
    output wire        is_retlit_out,
    output wire        is_retplain_out,
    output wire [7:0]  literal_out
);
    assign is_retint_out   = (opcode_in == `RTU_OPW_RETINT);
    assign is_retplain_out = (opcode_in == `RTU_OPW_RETPLAIN);
    assign is_retlit_out   = ((opcode_in & `RTU_OPW_RETLIT_MASK) == `RTU_OPW_RETLIT);
    assign literal_out     = opcode_in[7:0];
endmodule

// ### verilog/rtu_return_unit.v
// return instruction execution unit
`timescale 1ns/1ps
`include "rtu_defs.vh"
module rtu_return_unit #(
    parameter PC_W = 13
) (
    input  wire            core_clk_in,
    input  wire            nrst_in,
    input  wire            instr_valid_in,
    input  wire [13:0]     opcode_in,
    input  wire [PC_W-1:0] top_of_stack_in,
    input  wire [7:0]      interrupt_control_reg_in,
    output reg             busy_out,
    output reg             stack_pop_out,
    output reg             pc_load_out,
    output reg  [PC_W-1:0] pc_value_out,
    output reg             acc_load_out,
    output reg  [7:0]      acc_value_out,
    output reg             int_ctl_load_out,
    output reg  [7:0]      int_ctl_value_out,
    output reg             flush_out,
    output reg             done_out
);
    // ================================================================
    // state encoding
    localparam [1:0] ST_IDLE  = 2'h1;
    localparam [1:0] ST_RUN   = 2'h2;
    localparam [3:0] CYC_LAST = `RTU_RET_CYCLES - 4'h1;

    // ================================================================
    // internal signals
    wire            is_int;
    wire            is_lit;
    wire            is_plain;
    wire            is_return;
    wire [7:0]      lit;
    wire [7:0]      ctl_merged;
    wire            idle;
    wire            run;
    wire            start;
    wire            last_cyc;

    reg  [1:0]      state_r;
    reg  [1:0]      state_nxt;
    reg  [3:0]      cyc_r;
    reg  [3:0]      cyc_nxt;
    reg             busy_nxt;
    reg             stack_pop_nxt;
    reg             pc_load_nxt;
    reg  [PC_W-1:0] pc_value_nxt;
    reg             acc_load_nxt;
    reg  [7:0]      acc_value_nxt;
    reg             int_ctl_load_nxt;
    reg  [7:0]      int_ctl_value_nxt;
    reg             flush_nxt;
    reg             done_nxt;

    // ================================================================
    // opcode classification
    rtu_op_decode u_dec (
        .opcode_in       (opcode_in),
        .is_retint_out   (is_int),
        .is_retlit_out   (is_lit),
        .is_retplain_out (is_plain),
        .literal_out     (lit)
    );

    // ================================================================
    // request qualifier
    assign idle      = (state_r == ST_IDLE);
    assign run       = (state_r == ST_RUN);
    assign is_return = is_int | is_lit | is_plain;
    // a return offered while one is still running is ignored
    assign start     = instr_valid_in & is_return & idle;
    // the last cycle is the second instruction cycle of the return, the first cycle in ST_RUN
    assign last_cyc  = run & (cyc_r == CYC_LAST);

    // ================================================================
    // control register image with the global enable forced on
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_ctl_bit
            if (g == `RTU_GLOBAL_INT_EN_BIT) begin : g_set
                assign ctl_merged[g] = 1'b1;
            end else begin : g_keep
                assign ctl_merged[g] = interrupt_control_reg_in[g];
            end
        end
    endgenerate

    // ================================================================
    // next state and cycle count
    always @* begin
        state_nxt = state_r;
        cyc_nxt   = cyc_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_RUN;
                    cyc_nxt   = 4'h1;
                end
            end
            ST_RUN: begin
                if (last_cyc) begin
                    state_nxt = ST_IDLE;
                    cyc_nxt   = 4'h0;
                end else begin
                    cyc_nxt   = cyc_r + 4'h1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cyc_nxt   = 4'h0;
            end
        endcase
    end

    // ================================================================
    // one-cycle strobes
    always @* begin
        busy_nxt         = 1'b0;
        stack_pop_nxt    = 1'b0;
        pc_load_nxt      = 1'b0;
        acc_load_nxt     = 1'b0;
        int_ctl_load_nxt = 1'b0;
        flush_nxt        = 1'b0;
        done_nxt         = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    busy_nxt         = 1'b1;
                    stack_pop_nxt    = 1'b1;
                    pc_load_nxt      = 1'b1;
                    flush_nxt        = 1'b1;
                    acc_load_nxt     = is_lit;
                    int_ctl_load_nxt = is_int;
                end
            end
            ST_RUN: begin
                busy_nxt = ~last_cyc;
                done_nxt = last_cyc;
            end
            default: begin
                busy_nxt = 1'b0;
            end
        endcase
    end

    // ================================================================
    // values handed over, each held until the next return that loads it
    always @* begin
        pc_value_nxt      = pc_value_out;
        acc_value_nxt     = acc_value_out;
        int_ctl_value_nxt = int_ctl_value_out;
        if (start) begin
            pc_value_nxt = top_of_stack_in;
            if (is_lit) begin
                acc_value_nxt = lit;
            end
            if (is_int) begin
                int_ctl_value_nxt = ctl_merged;
            end
        end
    end

    // ================================================================
    // state registers
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_r <= ST_IDLE;
            cyc_r   <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cyc_r   <= cyc_nxt;
        end
    end

    // ================================================================
    // strobe registers
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            busy_out         <= 1'b0;
            stack_pop_out    <= 1'b0;
            pc_load_out      <= 1'b0;
            acc_load_out     <= 1'b0;
            int_ctl_load_out <= 1'b0;
            flush_out        <= 1'b0;
            done_out         <= 1'b0;
        end else begin
            busy_out         <= busy_nxt;
            stack_pop_out    <= stack_pop_nxt;
            pc_load_out      <= pc_load_nxt;
            acc_load_out     <= acc_load_nxt;
            int_ctl_load_out <= int_ctl_load_nxt;
            flush_out        <= flush_nxt;
            done_out         <= done_nxt;
        end
    end

    // ================================================================
    // value registers
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            pc_value_out      <= `RTU_PC_RST;
            acc_value_out     <= `RTU_ACC_RST;
            int_ctl_value_out <= `RTU_CTL_RST;
        end else begin
            pc_value_out      <= pc_value_nxt;
            acc_value_out     <= acc_value_nxt;
            int_ctl_value_out <= int_ctl_value_nxt;
        end
    end
endmodule

// ### testbench/rtu_chk_assertions.sv
// return unit port checks
`timescale 1ns/1ps
module rtu_chk (
    input wire core_clk_in, nrst_in, instr_valid_in, busy_out, stack_pop_out, flush_out,
    input wire acc_load_out, int_ctl_load_out, done_out, pc_load_out,
    input wire [13:0] opcode_in,
    input wire [12:0] top_of_stack_in, pc_value_out,
    input wire [7:0] acc_value_out, int_ctl_value_out);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    wire ok = instr_valid_in && !busy_out;
    wire ri = ok && opcode_in == 14'h0009;
    wire rl = ok && opcode_in[13:10] == 4'hd;
    wire tk = ri || rl || ok && opcode_in == 14'h0008;
    AST_PC: assert property (tk |=> pc_load_out
        && pc_value_out == $past(top_of_stack_in))
        else $error("pc");
    AST_GLOBAL_EN: assert property (ri |=> int_ctl_load_out && int_ctl_value_out[7])
        else $error("enable");
    AST_NO_CTL_LOAD: assert property (!ri |=> !int_ctl_load_out)
        else $error("ctl");
    AST_ACC: assert property (rl |=> acc_load_out
        && acc_value_out == $past(opcode_in[7:0]))
        else $error("acc");
    AST_NOACC: assert property (!rl |=> !acc_load_out)
        else $error("acl");
    AST_TWO: assert property (tk |=> !done_out ##1 done_out)
        else $error("cyc");
    AST_FLUSH: assert property (tk |=> flush_out && busy_out && stack_pop_out)
        else $error("fl");
    AST_ONE: assert property (!tk |=> !stack_pop_out && !flush_out)
        else $error("pop");
endmodule

// ### testbench/rtu_core.sv
// return stack and control register model
`timescale 1ns/1ps
module rtu_core (
    input  wire        core_clk_in, nrst_in, stack_pop_out,
    output wire [12:0] top_of_stack_in,
    output wire [7:0]  interrupt_control_reg_in);
    reg [2:0] sp_r = 3'h7;
    assign top_of_stack_in = {sp_r, ~sp_r, 7'h2b};
    assign interrupt_control_reg_in = {sp_r, 5'h0a};
    always @(posedge core_clk_in) sp_r <= nrst_in ? sp_r - stack_pop_out : 3'h7;
endmodule

// ### testbench/testbench.sv
// bench for the return unit
`timescale 1ns/1ps
module testbench;
    reg core_clk_in = 0, nrst_in = 0, instr_valid_in = 0;
    reg [13:0] opcode_in = 14'h0;
    reg [31:0] k;
    integer seed = 32'h8321, err_count = 0, n_compared = 0, i;
    reg [30:0] q[$];
    reg [30:0] got;
    wire busy_out, stack_pop_out, pc_load_out, acc_load_out, int_ctl_load_out, flush_out, done_out;
    wire [12:0] top_of_stack_in, pc_value_out;
    wire [7:0] interrupt_control_reg_in, acc_value_out, int_ctl_value_out;
    always #20 core_clk_in = ~core_clk_in;
    rtu_return_unit dut (.*);
    rtu_core core (.*);
    task stop_test;
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input [30:0] seen, exp);
        n_compared++;
        if (seen !== exp) err_count++;
        if (seen !== exp) $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    endtask
    always @(negedge core_clk_in) begin
        if (pc_load_out) begin
            got = {int_ctl_load_out, acc_load_out, acc_load_out ? acc_value_out : 8'h0,
                   int_ctl_load_out ? int_ctl_value_out : 8'h0, pc_value_out};
            check(got, q.pop_front());
        end
    end
    initial begin
        repeat (6) @(negedge core_clk_in);
        nrst_in = 1;
        for (i = 0; i < 60; i++) begin
            @(negedge core_clk_in);
            k = $random(seed);
            opcode_in = k[9] ? {k[8] ? 6'h01 : {4'hd, k[11:10]}, k[7:0]} : {13'h4, !k[8]};
            instr_valid_in = k[12];
            if (k[12] && k[9:8] != 3) begin
                q.push_back({k[9:8] == 0, k[9:8] == 2, k[9:8] == 2 ? k[7:0] : 8'h0,
                    k[9:8] == 0 ? interrupt_control_reg_in | 8'h80 : 8'h0, top_of_stack_in});
                @(negedge core_clk_in);
                opcode_in = k[27:14];
            end
        end
        @(negedge core_clk_in);
        instr_valid_in = 0;
        repeat (3) @(negedge core_clk_in);
        check(31'(q.size()), 31'h0);
        stop_test;
    end
    initial begin
        #20000;
        err_count++;
        stop_test;
    end
endmodule
bind rtu_return_unit rtu_chk chk (.*);
